// file: core/sit_target.sv
// Two-wire bus target with register pointer access and standby/active mode control
`default_nettype none
module sit_target (
    input wire logic clk, // System clock, 125 MHz
    input wire logic reset_n, // Asynchronous power-on reset, active low
    input wire logic scl_in, // Bus clock pin, input only
    input wire logic sda_in, // Bus data pin level
    output logic sda_out, // Bus data drive value, always low
    output logic sda_oe, // High while pulling the data line low
    output logic bus_busy, // Bus held between start and stop
    output logic [7:0] reg_addr, // Register pointer to the register file
    output logic [7:0] reg_wdata, // Byte written by the master
    output logic reg_wr, // One-cycle write strobe
    output logic reg_rd, // One-cycle read strobe, data taken on the edge that raises it
    input wire logic [7:0] reg_rdata, // Register file data at reg_addr
    output logic active_mode_select, // Control bit: 1 active, 0 standby
    output logic analog_enable // Analog subsystem and acquisition enable
);
    import sit_pkg::*;

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    sit_state_t state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic rw;
    logic first_byte;
    logic master_ack;
    logic [7:0] primary_control_register;
    logic [7:0] rd_byte;
    logic ctrl_hit;

    sit_glitch_filter u_scl_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw(scl_in),
        .filt(scl_f)
    );

    sit_glitch_filter u_sda_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw(sda_in),
        .filt(sda_f)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // Open-drain data line; the clock line has no driver at all
    assign sda_out = 1'b0;
    assign start_ev = scl_f && scl_q && sda_q && !sda_f;
    assign stop_ev = scl_f && scl_q && !sda_q && sda_f;
    // Edges only; a clock held low simply produces no event
    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;

    assign ctrl_hit = (reg_addr == PRIMARY_CTRL_ADDR);
    // Control register is served locally; all others come from the register file
    assign rd_byte = ctrl_hit ? primary_control_register : reg_rdata;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_busy <= 1'b0;
        end else if (start_ev) begin
            bus_busy <= 1'b1;
        end else if (stop_ev) begin
            bus_busy <= 1'b0;
        end
    end

    // Mode follows the control bit; bus access is never gated by it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            primary_control_register <= PRIMARY_CTRL_RESET;
        end else if (state == SIT_WR_BYTE && scl_fall && bit_cnt == BIT_CNT_BYTE
                     && !first_byte && ctrl_hit) begin
            primary_control_register <= shift;
        end
    end

    assign active_mode_select = primary_control_register[ACTIVE_BIT];
    assign analog_enable = active_mode_select;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SIT_IDLE;
            shift <= '0;
            bit_cnt <= '0;
            rw <= 1'b0;
            first_byte <= 1'b0;
            master_ack <= 1'b0;
            sda_oe <= 1'b0;
            reg_addr <= PTR_RESET;
            reg_wdata <= '0;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (start_ev) begin
                // Also serves a repeated start; the pointer is kept
                state <= SIT_ADDR;
                bit_cnt <= '0;
                sda_oe <= 1'b0;
            end else if (stop_ev) begin
                state <= SIT_IDLE;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    SIT_IDLE, SIT_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    SIT_ADDR, SIT_WR_BYTE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 1'b1;
                        end else if (scl_fall && bit_cnt == BIT_CNT_BYTE) begin
                            if (state == SIT_ADDR) begin
                                if (shift[7:1] == TARGET_ADDR) begin
                                    rw <= shift[0];
                                    sda_oe <= 1'b1;
                                    state <= SIT_ADDR_ACK;
                                end else begin
                                    state <= SIT_IGNORE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                state <= SIT_WR_ACK;
                                first_byte <= 1'b0;
                                if (first_byte) begin
                                    reg_addr <= shift;
                                end else begin
                                    reg_wdata <= shift;
                                    reg_wr <= !ctrl_hit;
                                    // Pointer walks on and wraps from the top back to zero for long bursts
                                    reg_addr <= reg_addr + 1'b1;
                                end
                            end
                        end
                    end
                    SIT_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= '0;
                            if (rw) begin
                                shift <= rd_byte;
                                reg_rd <= 1'b1;
                                sda_oe <= !rd_byte[7];
                                state <= SIT_RD_BYTE;
                            end else begin
                                sda_oe <= 1'b0;
                                first_byte <= 1'b1;
                                state <= SIT_WR_BYTE;
                            end
                        end
                    end
                    SIT_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_cnt <= '0;
                            state <= SIT_WR_BYTE;
                        end
                    end
                    SIT_RD_BYTE: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end else if (scl_fall) begin
                            if (bit_cnt == BIT_CNT_BYTE) begin
                                sda_oe <= 1'b0;
                                reg_addr <= reg_addr + 1'b1;
                                state <= SIT_RD_ACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe <= !shift[6];
                            end
                        end
                    end
                    SIT_RD_ACK: begin
                        if (scl_rise) begin
                            master_ack <= !sda_f;
                        end else if (scl_fall) begin
                            bit_cnt <= '0;
                            if (master_ack) begin
                                shift <= rd_byte;
                                reg_rd <= 1'b1;
                                sda_oe <= !rd_byte[7];
                                state <= SIT_RD_BYTE;
                            end else begin
                                // No acknowledge ends the read; wait for stop or start
                                state <= SIT_IGNORE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    property p_oe_on_fall;
        @(posedge clk) disable iff (!reset_n)
        $changed(sda_oe) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev);
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall)
        else $error("data drive changed away from a clock fall");

    property p_busy_set;
        @(posedge clk) disable iff (!reset_n)
        start_ev |=> bus_busy;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("bus not busy after start");

    property p_busy_clr;
        @(posedge clk) disable iff (!reset_n)
        stop_ev |=> !bus_busy && state == SIT_IDLE;
    endproperty
    a_busy_clr: assert property (p_busy_clr)
        else $error("bus still busy after stop");

    property p_addr_match;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_ADDR && scl_fall && !start_ev && !stop_ev && bit_cnt == 4'h8
            && shift[7:1] == 7'h60 |=> state == SIT_ADDR_ACK && sda_oe;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("own address not acknowledged");

    property p_addr_miss;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_ADDR && scl_fall && !start_ev && !stop_ev && bit_cnt == 4'h8
            && shift[7:1] != 7'h60 |=> state == SIT_IGNORE && !sda_oe;
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("foreign address not ignored");

    property p_ack_held;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_ADDR_ACK || state == SIT_WR_ACK |-> sda_oe;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("acknowledge released early");

    property p_rd_release;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_RD_ACK || state == SIT_IGNORE || state == SIT_IDLE |-> !sda_oe;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("data line driven in master acknowledge");

    property p_pointer_load;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_WR_BYTE && first_byte && scl_fall && !start_ev && !stop_ev
            && bit_cnt == 4'h8 |=> reg_addr == $past(shift) && !reg_wr;
    endproperty
    a_pointer_load: assert property (p_pointer_load)
        else $error("register pointer not loaded by first byte");

    property p_burst;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_WR_ACK && scl_fall && !start_ev && !stop_ev
            |=> state == SIT_WR_BYTE && bit_cnt == 4'h0;
    endproperty
    a_burst: assert property (p_burst)
        else $error("write burst cut short");

    property p_mode;
        @(posedge clk) disable iff (!reset_n)
        state == SIT_WR_BYTE && scl_fall && !first_byte && bit_cnt == 4'h8 && reg_addr == 8'h20
            |=> active_mode_select == $past(shift[0]) && analog_enable == active_mode_select;
    endproperty
    a_mode: assert property (p_mode)
        else $error("analog enable disagrees with control bit");
endmodule : sit_target
`default_nettype wire

// file: include/sit_pkg.sv
// Shared constants and types for the sensor two-wire target and mode control
`default_nettype none
package sit_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // Spikes up to this width are suppressed on both bus inputs
    localparam int SPIKE_NS = 50;
    // Rounded up: a spike that covers the most clock samples must still be rejected
    localparam int SPIKE_CYC_RAW = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
    localparam int FILT_W = 4;
    localparam logic [FILT_W-1:0] FILT_CYC = FILT_W'(SPIKE_CYC);

    localparam logic [6:0] TARGET_ADDR = 7'h60;
    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

    // Internal primary control register, reached only over the two-wire bus
    localparam logic [7:0] PRIMARY_CTRL_ADDR = 8'h20;
    localparam logic [7:0] PRIMARY_CTRL_RESET = 8'h00;
    localparam int ACTIVE_BIT = 0;
    localparam logic [7:0] PTR_RESET = 8'h00;

    typedef enum logic [2:0] {
        SIT_IDLE = 3'b000,
        SIT_ADDR = 3'b001,
        SIT_ADDR_ACK = 3'b010,
        SIT_WR_BYTE = 3'b011,
        SIT_WR_ACK = 3'b100,
        SIT_RD_BYTE = 3'b101,
        SIT_RD_ACK = 3'b110,
        SIT_IGNORE = 3'b111
    } sit_state_t;
endpackage : sit_pkg
`default_nettype wire

// file: core/sit_glitch_filter.sv
// Two-flop synchroniser followed by a spike-suppressing stability filter
`default_nettype none
module sit_glitch_filter (
    input wire logic clk, // System clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic raw, // Bus line from the pin
    output logic filt // Filtered, synchronised level
);
    import sit_pkg::*;

    logic meta;
    logic sync;
    logic [FILT_W-1:0] cnt;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b1;
            sync <= 1'b1;
        end else begin
            meta <= raw;
            sync <= meta;
        end
    end

    // A new level must hold longer than the spike width before it is taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
            filt <= 1'b1;
        end else if (sync == filt) begin
            cnt <= '0;
        end else if (cnt == FILT_CYC) begin
            cnt <= '0;
            filt <= sync;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule : sit_glitch_filter
`default_nettype wire

// file: dv/sit_host.sv
// Behavioural two-wire bus master that drives the target from the far side
`default_nettype none
module sit_host (
    input wire logic clk, // System clock pacing every bus phase
    input wire logic sda, // Resolved data line level
    output logic scl, // Bus clock, only the master drives it
    output logic sda_low // High while the master pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Edges land 1 ns after a clock edge so sampling never races
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic start_cond;
        wait_clk(40);
        sda_low = 1'b0;
        wait_clk(40);
        scl = 1'b1;
        wait_clk(80);
        sda_low = 1'b1;
        wait_clk(80);
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        wait_clk(40);
        sda_low = 1'b1;
        wait_clk(130);
        scl = 1'b1;
        wait_clk(80);
        sda_low = 1'b0;
        wait_clk(170);
    endtask : stop_cond

    // Low phase 170 clk, high phase 80 clk; spike flips data for 40 ns while clock is high
    task automatic send_bit(input logic b, input logic spike, output logic got);
        wait_clk(50);
        sda_low = ~b;
        wait_clk(120);
        scl = 1'b1;
        wait_clk(20);
        if (spike) begin
            sda_low = ~sda_low;
            wait_clk(5);
            sda_low = ~sda_low;
            wait_clk(15);
        end else begin
            wait_clk(20);
        end
        got = sda;
        wait_clk(40);
        scl = 1'b0;
    endtask : send_bit

    task automatic write_byte(input logic [7:0] d, input logic spike, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i], spike, g);
        end
        send_bit(1'b1, 1'b0, g);
        ack = ~g;
    endtask : write_byte

    task automatic read_byte(input logic ack, output logic [7:0] d, output logic line);
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'b1, 1'b0, d[i]);
        end
        send_bit(~ack, 1'b0, line);
    endtask : read_byte
endmodule : sit_host
`default_nettype wire

// file: dv/sit_target_test.sv
// Self-checking testbench for the two-wire target and mode control
`default_nettype none
module sit_target_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sit_pkg::*;

    logic clk, reset_n, scl, sda_low, sda, sda_out, sda_oe, bus_busy;
    logic reg_wr, reg_rd, active_mode_select, analog_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [15:0] wr_log[$];
    int rd_count, fail_count, checked;

    // Pull-up: released line reads high
    assign sda = ~(sda_low | (sda_oe & ~sda_out));
    assign reg_rdata = reg_addr ^ 8'h5a;

    sit_target sit_target_inst (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .active_mode_select(active_mode_select), .analog_enable(analog_enable));
    sit_host sit_host_inst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Write strobe shows the pointer already advanced, so log pointer minus one
    always @(posedge clk) begin
        if (reg_wr === 1'b1) wr_log.push_back({reg_addr - 8'h01, reg_wdata});
        if (reg_rd === 1'b1) rd_count++;
    end

    task automatic check1(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask : check1

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task automatic wr(input logic [7:0] d, input logic spike, input logic exp_ack);
        logic a;
        sit_host_inst.write_byte(d, spike, a);
        check1("ack", exp_ack, a);
    endtask : wr

    task automatic rd(input logic ack, input logic [7:0] exp);
        logic [7:0] d;
        logic line;
        sit_host_inst.read_byte(ack, d, line);
        check8("read data", exp, d);
        if (!ack) check1("released after nack", 1'b1, line);
    endtask : rd

    task automatic open_write(input logic [7:0] ptr);
        sit_host_inst.start_cond();
        wr(8'hc0, 1'b0, 1'b1);
        wr(ptr, 1'b0, 1'b1);
    endtask : open_write

    task automatic t_reset;
        check1("busy", 1'b0, bus_busy);
        check1("sda drive", 1'b0, sda_oe);
        check1("mode", 1'b0, active_mode_select);
        check1("analog", 1'b0, analog_enable);
    endtask : t_reset

    // Reset in mid-run with the bus idle must fall back to standby
    task automatic t_mid_reset;
        reset_n = 1'b0;
        sit_host_inst.wait_clk(3);
        reset_n = 1'b1;
        sit_host_inst.wait_clk(20);
        t_reset();
    endtask : t_mid_reset

    task automatic t_mode(input logic [7:0] v);
        open_write(PRIMARY_CTRL_ADDR);
        wr(v, 1'b0, 1'b1);
        check1("busy", 1'b1, bus_busy);
        sit_host_inst.stop_cond();
        check1("busy", 1'b0, bus_busy);
        check1("mode", v[0], active_mode_select);
        check1("analog", v[0], analog_enable);
    endtask : t_mode

    task automatic t_random_read(input logic [7:0] ptr, input logic [7:0] e0, input int n);
        rd_count = 0;
        open_write(ptr);
        sit_host_inst.start_cond();
        wr(8'hc1, 1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            rd(i < n - 1, (i == 0) ? e0 : (ptr + 8'(i)) ^ 8'h5a);
        end
        sit_host_inst.stop_cond();
    endtask : t_random_read

    task automatic t_burst;
        wr_log.delete();
        open_write(8'h10);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) sit_host_inst.wait_clk(1000);
            wr(8'ha0 + 8'(i), 1'b0, 1'b1);
        end
        sit_host_inst.stop_cond();
        check8("write count", 8'h04, 8'(wr_log.size()));
        foreach (wr_log[i]) begin
            check8("write addr", 8'h10 + 8'(i), wr_log[i][15:8]);
            check8("write data", 8'ha0 + 8'(i), wr_log[i][7:0]);
        end
    endtask : t_burst

    task automatic t_wrong_addr;
        logic [7:0] bad[3] = '{8'hc2, 8'h40, 8'he0};
        wr_log.delete();
        foreach (bad[i]) begin
            sit_host_inst.start_cond();
            wr(bad[i], 1'b0, 1'b0);
            wr(8'h55, 1'b0, 1'b0);
            sit_host_inst.stop_cond();
        end
        check8("write count", 8'h00, 8'(wr_log.size()));
    endtask : t_wrong_addr

    task automatic t_spike;
        wr_log.delete();
        sit_host_inst.start_cond();
        wr(8'hc0, 1'b1, 1'b1);
        wr(8'h11, 1'b1, 1'b1);
        wr(8'h77, 1'b1, 1'b1);
        sit_host_inst.stop_cond();
        check8("write count", 8'h01, 8'(wr_log.size()));
        check8("write addr", 8'h11, wr_log[0][15:8]);
        check8("write data", 8'h77, wr_log[0][7:0]);
    endtask : t_spike

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        $display("ERROR watchdog expired before the tests ended");
        end_sim();
    end

    initial begin
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        sit_host_inst.wait_clk(20);
        t_reset();
        t_mode(8'h01);
        t_random_read(PRIMARY_CTRL_ADDR, 8'h01, 1);
        t_mid_reset();
        t_mode(8'h00);
        t_random_read(8'h30, 8'h30 ^ 8'h5a, 2);
        check8("read strobes", 8'h02, 8'(rd_count));
        t_burst();
        t_wrong_addr();
        t_spike();
        end_sim();
    end
endmodule : sit_target_test
`default_nettype wire
